// ==== logic/dpr_responder.sv ====
// Serial responder returning a fixed 256-byte parameter table.
// Assumes serial pins are synchronous to mclk and each serial clock
// phase lasts at least two mclk cycles.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_map.svh"

module dpr_responder #(
  parameter logic [7:0] MAKER_CODE = 8'h3c  // Arbitrary value
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Serial pins
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic si,
  output var  logic so,
  output var  logic so_oe,
  // Status
  output var  logic table_read_active,
  output var  logic addr_high_nonzero
);
  import dpr_pkg::*;

  // ==========================================================
  // Table lookup
  // fixed table contents
  function automatic logic [7:0] dpr_table_byte(input logic [7:0] a);
    logic [7:0] v;
    v = `DPR_VAL_RSVD;
    case (a)
      `DPR_OFS_SIG0:       v = `DPR_VAL_SIG0;
      `DPR_OFS_SIG1:       v = `DPR_VAL_SIG1;
      `DPR_OFS_SIG2:       v = `DPR_VAL_SIG2;
      `DPR_OFS_SIG3:       v = `DPR_VAL_SIG3;
      `DPR_OFS_MINOR:      v = `DPR_VAL_MINOR;
      `DPR_OFS_MAJOR:      v = `DPR_VAL_MAJOR;
      `DPR_OFS_HDR_COUNT:  v = `DPR_VAL_HDR_COUNT;
      `DPR_OFS_RSVD_07:    v = `DPR_VAL_RSVD;
      `DPR_OFS_H0_MAKER:   v = MAKER_CODE;
      `DPR_OFS_H1_MAKER:   v = MAKER_CODE;
      `DPR_OFS_H0_MINOR:   v = `DPR_VAL_H0_MINOR;
      `DPR_OFS_H0_MAJOR:   v = `DPR_VAL_H0_MAJOR;
      `DPR_OFS_H0_LEN:     v = `DPR_VAL_H0_LEN;
      `DPR_OFS_H0_PTR_LO:  v = `DPR_VAL_H0_PTR_LO;
      `DPR_OFS_H0_PTR_MID: v = `DPR_VAL_PTR_UPPER;
      `DPR_OFS_H0_PTR_HI:  v = `DPR_VAL_PTR_UPPER;
      `DPR_OFS_RSVD_0F:    v = `DPR_VAL_RSVD;
      `DPR_OFS_H1_MINOR:   v = `DPR_VAL_H1_MINOR;
      `DPR_OFS_H1_MAJOR:   v = `DPR_VAL_H1_MAJOR;
      `DPR_OFS_H1_LEN:     v = `DPR_VAL_H1_LEN;
      `DPR_OFS_H1_PTR_LO:  v = `DPR_VAL_H1_PTR_LO;
      `DPR_OFS_H1_PTR_MID: v = `DPR_VAL_PTR_UPPER;
      `DPR_OFS_H1_PTR_HI:  v = `DPR_VAL_PTR_UPPER;
      `DPR_OFS_RSVD_17:    v = `DPR_VAL_RSVD;
      `DPR_OFS_CAP_FLAGS:  v = `DPR_VAL_CAP_FLAGS;
      `DPR_OFS_ERASE_OPC:  v = `DPR_VAL_ERASE_OPC;
      default:             v = `DPR_VAL_RSVD;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Phase lengths
  // Last bit index of each counted phase; data reuses the opcode length
  function automatic logic [4:0] dpr_phase_last(input dpr_state_t s);
    logic [4:0] n;
    n = `DPR_OPC_LAST;
    case (s)
      DPR_ST_ADDR:  n = `DPR_ADDR_LAST;
      DPR_ST_DUMMY: n = `DPR_DUMMY_LAST;
      default:      n = `DPR_OPC_LAST;
    endcase
    return n;
  endfunction

  // ==========================================================
  // Table image
  // whole table built once, read path is a plain index
  logic [7:0] table_rom [256];
  for (genvar g = 0; g < 256; g++) begin : g_rom
    assign table_rom[g] = dpr_table_byte(8'(g));
  end

  // ==========================================================
  // Registers
  dpr_state_t  state_r;
  dpr_state_t  state_nxt;
  logic        sclk_d_r;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic [7:0]  opc_r;
  logic [23:0] addr_r;
  logic [7:0]  idx_r;
  logic [7:0]  idx_nxt;
  logic [7:0]  obyte_r;
  logic [7:0]  obyte_nxt;
  logic [2:0]  obit_r;
  logic [2:0]  obit_nxt;
  logic        so_nxt;
  logic        so_oe_nxt;
  logic [7:0]  opc_nxt;
  logic [23:0] addr_nxt;
  logic        table_read_active_nxt;
  logic        addr_high_nonzero_nxt;

  // ==========================================================
  // Edge detection and phase decode
  // Edges only count while selected; stray clocks while idle are dropped
  wire        sel       = ~cs_n;
  wire        rise      = sel & ~sclk_d_r & sclk;
  wire        fall      = sel & sclk_d_r & ~sclk;
  wire [7:0]  opc_word  = {opc_r[6:0], si};
  wire [23:0] addr_word = {addr_r[22:0], si};
  wire [4:0]  cnt_last  = dpr_phase_last(state_r);
  wire        phase_end = rise & (cnt_r == cnt_last);
  wire        in_opc    = (state_r == DPR_ST_OPCODE);
  wire        in_addr   = (state_r == DPR_ST_ADDR);
  wire        in_data   = (state_r == DPR_ST_DATA);
  wire        opc_step  = rise & in_opc;
  wire        addr_step = rise & in_addr;
  wire        addr_done = phase_end & in_addr;
  wire        clr       = srst | cs_n;
  wire        load_byte = fall & in_data & (obit_r == 3'h0);
  wire        shift_bit = fall & in_data & (obit_r != 3'h0);
  wire [7:0]  tbl_byte  = table_rom[idx_r];

  // ==========================================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DPR_ST_OPCODE: begin
        if (phase_end) begin
          state_nxt = (opc_word == `DPR_OPC_READ_TABLE) ? DPR_ST_ADDR : DPR_ST_IGNORE;
        end
      end
      DPR_ST_ADDR: begin
        if (phase_end) begin
          state_nxt = DPR_ST_DUMMY;
        end
      end
      DPR_ST_DUMMY: begin
        if (phase_end) begin
          state_nxt = DPR_ST_DATA;
        end
      end
      DPR_ST_DATA:   state_nxt = DPR_ST_DATA;
      DPR_ST_IGNORE: state_nxt = DPR_ST_IGNORE;
      default:       state_nxt = DPR_ST_IGNORE;
    endcase
  end

  // Phase bit counter
  assign cnt_nxt = phase_end ? 5'h00 : (rise ? cnt_r + 5'h01 : cnt_r);

  assign idx_nxt = (phase_end && state_r == DPR_ST_ADDR) ? addr_word[7:0] :
                   (load_byte ? idx_r + 8'h01 : idx_r);

  // first bit on 40th falling edge, MSB first
  assign obyte_nxt = load_byte ? {tbl_byte[6:0], 1'b0} :
                     (shift_bit ? {obyte_r[6:0], 1'b0} : obyte_r);
  assign obit_nxt  = load_byte ? `DPR_BIT_LAST : (shift_bit ? obit_r - 3'h1 : obit_r);
  assign so_nxt    = load_byte ? tbl_byte[7] : (shift_bit ? obyte_r[7] : so);
  assign so_oe_nxt = so_oe | load_byte;

  // shifters advance only in their phase
  assign opc_nxt  = opc_step ? opc_word : opc_r;
  assign addr_nxt = addr_step ? addr_word : addr_r;

  // active once data phase is entered
  assign table_read_active_nxt = (state_nxt == DPR_ST_DATA);
  // upper bits reported, never gate data
  assign addr_high_nonzero_nxt = addr_done ? (addr_word[23:8] != 16'h0000) : addr_high_nonzero;

  // ==========================================================
  // Serial clock history
  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk;
    end
  end

  // ==========================================================
  // Sequencer flops
  // deselect returns to opcode phase
  always_ff @(posedge mclk) begin
    if (clr) begin
      state_r <= DPR_ST_OPCODE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Command capture
  // opcode bits, MSB first
  always_ff @(posedge mclk) begin
    if (srst) begin
      opc_r <= 8'h00;
    end else begin
      opc_r <= opc_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_r <= 24'h000000;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // ==========================================================
  // Output path
  // byte index, cleared on deselect
  always_ff @(posedge mclk) begin
    if (clr) begin
      idx_r <= 8'h00;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      obyte_r <= 8'h00;
    end else begin
      obyte_r <= obyte_nxt;
    end
  end

  // bits left in the current byte
  always_ff @(posedge mclk) begin
    if (clr) begin
      obit_r <= 3'h0;
    end else begin
      obit_r <= obit_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      so <= 1'b0;
    end else begin
      so <= so_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= so_oe_nxt;
    end
  end

  // ==========================================================
  // Status
  // data phase indicator
  always_ff @(posedge mclk) begin
    if (clr) begin
      table_read_active <= 1'b0;
    end else begin
      table_read_active <= table_read_active_nxt;
    end
  end

  // held until the next address phase
  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_high_nonzero <= 1'b0;
    end else begin
      addr_high_nonzero <= addr_high_nonzero_nxt;
    end
  end

endmodule // dpr_responder
`default_nettype wire

// ==== shared/dpr_map.svh ====
// Constants for the parameter-table read responder: opcode, phase
// lengths, table offsets and fixed table contents.
// Assumes inclusion by bare name from the design file.
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH

// ==========================================================
// Command and phase lengths (last index of each phase)
`define DPR_OPC_READ_TABLE   8'h5a
`define DPR_OPC_LAST         5'h07
`define DPR_ADDR_LAST        5'h17
`define DPR_DUMMY_LAST       5'h07
`define DPR_BIT_LAST         3'h7

// ==========================================================
// Table offsets
`define DPR_OFS_SIG0         8'h00
`define DPR_OFS_SIG1         8'h01
`define DPR_OFS_SIG2         8'h02
`define DPR_OFS_SIG3         8'h03
`define DPR_OFS_MINOR        8'h04
`define DPR_OFS_MAJOR        8'h05
`define DPR_OFS_HDR_COUNT    8'h06
`define DPR_OFS_RSVD_07      8'h07
`define DPR_OFS_H0_MAKER     8'h08
`define DPR_OFS_H0_MINOR     8'h09
`define DPR_OFS_H0_MAJOR     8'h0a
`define DPR_OFS_H0_LEN       8'h0b
`define DPR_OFS_H0_PTR_LO    8'h0c
`define DPR_OFS_H0_PTR_MID   8'h0d
`define DPR_OFS_H0_PTR_HI    8'h0e
`define DPR_OFS_RSVD_0F      8'h0f
`define DPR_OFS_H1_MAKER     8'h10
`define DPR_OFS_H1_MINOR     8'h11
`define DPR_OFS_H1_MAJOR     8'h12
`define DPR_OFS_H1_LEN       8'h13
`define DPR_OFS_H1_PTR_LO    8'h14
`define DPR_OFS_H1_PTR_MID   8'h15
`define DPR_OFS_H1_PTR_HI    8'h16
`define DPR_OFS_RSVD_17      8'h17
`define DPR_OFS_CAP_FLAGS    8'h80
`define DPR_OFS_ERASE_OPC    8'h81

// ==========================================================
// Table contents
`define DPR_VAL_SIG0         8'h53
`define DPR_VAL_SIG1         8'h46
`define DPR_VAL_SIG2         8'h44
`define DPR_VAL_SIG3         8'h50
`define DPR_VAL_MINOR        8'h01
`define DPR_VAL_MAJOR        8'h01
`define DPR_VAL_HDR_COUNT    8'h00
`define DPR_VAL_H0_MINOR     8'h00
`define DPR_VAL_H0_MAJOR     8'h01
`define DPR_VAL_H0_LEN       8'h04
`define DPR_VAL_H0_PTR_LO    8'h80
`define DPR_VAL_H1_MINOR     8'h00
`define DPR_VAL_H1_MAJOR     8'h01
`define DPR_VAL_H1_LEN       8'h00
`define DPR_VAL_H1_PTR_LO    8'h90
`define DPR_VAL_PTR_UPPER    8'h00
`define DPR_VAL_CAP_FLAGS    8'he5
`define DPR_VAL_ERASE_OPC    8'h20
`define DPR_VAL_RSVD         8'hff

`endif

// ==== shared/dpr_pkg.sv ====
// Types for the parameter-table read responder.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dpr_pkg;
  // ==========================================================
  // Command sequencer states
  typedef enum logic [2:0] {
    DPR_ST_OPCODE,
    DPR_ST_ADDR,
    DPR_ST_DUMMY,
    DPR_ST_DATA,
    DPR_ST_IGNORE
  } dpr_state_t;
endpackage
`default_nettype wire

// ==== testbench/dpr_chk.sv ====
// Pin-level assertions for the parameter-table responder.
// Assumes a bind onto dpr_responder; serial pins sampled on mclk.
`timescale 1ns/1ps
`default_nettype none
module dpr_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  // Status
  input wire logic table_read_active,
  input wire logic addr_high_nonzero
);
  logic        sclk_r;
  logic [5:0]  rises_r;
  logic [7:0]  op_r;
  logic [23:0] addr_r;
  wire logic   rise  = !cs_n && sclk && !sclk_r;
  wire logic   fall  = !cs_n && !sclk && sclk_r;
  wire logic   op_ok = (op_r == 8'h5a);
  // =====
  // Edge count, saturating so long reads never wrap
  always_ff @(posedge mclk) begin
    sclk_r <= sclk;
    if (srst || cs_n) rises_r <= 6'h00;
    else if (rise && rises_r != 6'h3f) rises_r <= rises_r + 6'h01;
  end
  always_ff @(posedge mclk) begin
    if (rise && rises_r < 6'h08) op_r <= {op_r[6:0], si};
    if (rise && rises_r >= 6'h08 && rises_r < 6'h20) addr_r <= {addr_r[22:0], si};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_first_fall; fall && rises_r == 6'h28 && op_ok; endsequence
  sequence s_addr_end; rise && rises_r == 6'h1f && op_ok; endsequence
  property p_release; cs_n |=> !so_oe && !table_read_active; endproperty
  a_release: assert property (p_release) else $error("outputs kept after deselect");
  property p_early; rises_r < 6'h28 |-> !so_oe; endproperty
  a_early: assert property (p_early) else $error("output before dummy end");
  property p_bad_op; (rises_r >= 6'h08 && !op_ok) |-> !so_oe && !table_read_active; endproperty
  a_bad_op: assert property (p_bad_op) else $error("foreign opcode answered");
  property p_oe_start; s_first_fall |=> so_oe; endproperty
  a_oe_start: assert property (p_oe_start) else $error("no drive at first data fall");
  property p_active; s_first_fall |-> table_read_active; endproperty
  a_active: assert property (p_active) else $error("read not active");
  property p_oe_hold; (so_oe && !cs_n) |=> so_oe; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive dropped while selected");
  property p_quiet; !so_oe |-> !so; endproperty
  a_quiet: assert property (p_quiet) else $error("so high while undriven");
  property p_so_hold; (!cs_n && !fall) |=> $stable(so); endproperty
  a_so_hold: assert property (p_so_hold) else $error("so moved off a falling edge");
  property p_flag; s_addr_end |-> ##2 (addr_high_nonzero == (|addr_r[23:8])); endproperty
  a_flag: assert property (p_flag) else $error("upper address flag wrong");
endmodule // dpr_chk
`default_nettype wire

// ==== testbench/dpr_host.sv ====
// Behavioural serial host reading the parameter table.
// Assumes mclk-sampled pins; each serial clock phase is two mclk cycles.
`timescale 1ns/1ps
`default_nettype none
module dpr_host (
  // Clock
  input  wire logic mclk,
  // Serial pins
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic si,
  input  wire logic so,
  input  wire logic so_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // Sample so late in the low phase, then rise
  task automatic bit_clk(input logic b, output logic rx);
    @(posedge mclk) sclk <= 1'b0;
    si <= b;
    @(posedge mclk);
    @(posedge mclk) sclk <= 1'b1;
    // Undriven line reads inverted, so a missing enable shows
    rx = so_oe ? so : ~so;
    @(posedge mclk);
  endtask
  task automatic read(input logic [7:0] op, input logic [23:0] addr, input int nbits, output logic [7:0] q[$]);
    logic [31:0] cmd;
    logic        rx;
    logic [7:0]  sh;
    cmd = {op, addr};
    q.delete();
    @(posedge mclk) cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) bit_clk(cmd[i], rx);
    for (int i = 0; i < 8 + nbits; i++) begin
      bit_clk(~si, rx);
      sh = {sh[6:0], rx};
      if (i >= 8 && i % 8 == 7) q.push_back(sh);
    end
    @(posedge mclk) sclk <= 1'b0;
    @(posedge mclk) cs_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
endmodule // dpr_host
`default_nettype wire

// ==== testbench/tb_discoverable_parameter_read.sv ====
// Self-checking bench for the parameter-table responder.
// Assumes dpr_host and dpr_chk are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb_discoverable_parameter_read;
  localparam logic [7:0] MK = 8'h5e;  // Arbitrary maker code
  logic      mclk = 1'b0;
  logic      srst = 1'b1;
  wire logic cs_n, sclk, si, so, so_oe, table_read_active, addr_high_nonzero;
  int        fails = 0;
  int        comparisons = 0;
  int        cycles = 0;
  logic [7:0] q[$];
  logic [7:0] hdr [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h01, 8'h01, 8'h00, 8'hff, MK, 8'h00, 8'h01, 8'h04,
                           8'h80, 8'h00, 8'h00, 8'hff, MK, 8'h00, 8'h01, 8'h00, 8'h90, 8'h00, 8'h00, 8'hff};
  dpr_responder #(.MAKER_CODE(MK)) u_dut (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
    .so_oe(so_oe), .table_read_active(table_read_active), .addr_high_nonzero(addr_high_nonzero));
  dpr_host u_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
  initial forever #4 mclk = ~mclk;
  // =====
  // Report and scenarios
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_header;
    u_host.read(8'h5a, 24'h000000, 192, q);
    foreach (hdr[i]) `CHK(q[i], hdr[i])
    `CHK(addr_high_nonzero, 1'b0)
    $display("header test done");
  endtask
  task automatic t_caps;
    logic [7:0] e [6] = '{8'hff, 8'hff, 8'he5, 8'h20, 8'hff, 8'hff};
    u_host.read(8'h5a, 24'h00007e, 48, q);
    foreach (e[i]) `CHK(q[i], e[i])
    $display("capability test done");
  endtask
  task automatic t_wrap;
    u_host.read(8'h5a, 24'h0000ff, 24, q);
    `CHK({q[0], q[1], q[2]}, 24'hff5346)
    $display("wrap test done");
  endtask
  task automatic t_upper;
    u_host.read(8'h5a, 24'h012304, 24, q);
    `CHK({q[0], q[1], q[2]}, 24'h010100)
    `CHK(addr_high_nonzero, 1'b1)
    $display("upper address test done");
  endtask
  task automatic t_badop;
    u_host.read(8'h03, 24'h000000, 16, q);
    `CHK({q[0], q[1]}, 16'hffff)
    $display("foreign opcode test done");
  endtask
  task automatic t_partial;
    u_host.read(8'h5a, 24'h000010, 12, q);
    `CHK(q[0], MK)
    u_host.read(8'h5a, 24'h000000, 8, q);
    `CHK(q[0], 8'h53)
    $display("partial byte test done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    t_upper;
    t_header;
    t_caps;
    t_wrap;
    t_badop;
    t_partial;
    results;
  end
  // Hang guard, well above the few thousand cycles expected
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results;
    end
  end
endmodule // tb_discoverable_parameter_read
bind dpr_responder dpr_chk u_chk (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
  .so_oe(so_oe), .table_read_active(table_read_active), .addr_high_nonzero(addr_high_nonzero));
`default_nettype wire
